// ### shared/lfbm_consts.vh
`ifndef LFBM_CONSTS_VH
`define LFBM_CONSTS_VH

// Register offsets on the plain register port
`define LFBM_REG_CTRL      8'h00
`define LFBM_REG_URUN_THR  8'h04
`define LFBM_REG_CTS_TMO   8'h08
`define LFBM_REG_POOL_TBL  8'h0C
`define LFBM_REG_ASG_PTR   8'h10
`define LFBM_REG_ASG_NUM   8'h14
`define LFBM_REG_STATUS    8'h18
`define LFBM_REG_URUN_CNT  8'h1C

// Control register fields
`define LFBM_CTRL_NARROW   0

// Reset values
`define LFBM_CTRL_RST      32'h0000_0000
`define LFBM_URUN_THR_RST  16'h0004
`define LFBM_CTS_TMO_RST   32'h0000_1000
`define LFBM_POOL_TBL_RST  32'h0000_0000

// Frame descriptor word offsets
`define LFBM_FD_NEXT       32'h0000_0000
`define LFBM_FD_CTL        32'h0000_0004
`define LFBM_FD_LEN        32'h0000_0008
`define LFBM_FD_BUF        32'h0000_000C

// Descriptor control word fields
`define LFBM_CTL_LIP       0
`define LFBM_CTL_RED       1
`define LFBM_CTL_FT_LO     2
`define LFBM_CTL_FT_HI     4
`define LFBM_CTL_LINK_LO   16
`define LFBM_CTL_LINK_HI   31

// Link states that forbid connectionless frames
`define LFBM_LS_NOID       2'h0
`define LFBM_LS_AWID       2'h1

// Memory access sizes
`define LFBM_SZ_BYTE       2'h0
`define LFBM_SZ_HALF       2'h1
`define LFBM_SZ_WORD       2'h2

`endif

// ### verilog/lfbm_top.v
`timescale 1ns/1ps
`include "lfbm_consts.vh"

module lfbm_top #(
  parameter POOL_W    = 13,
  parameter INT_POOLS = 16,
  parameter LEN_W     = 16
) (
  input  wire              CLK,
  input  wire              SYS_RST,
  input  wire [7:0]        REG_ADDR,
  input  wire [31:0]       REG_WDATA,
  input  wire              REG_WR,
  input  wire              REG_RD,
  output reg  [31:0]       REG_RDATA,
  input  wire              TXD_REQ,
  input  wire [LEN_W-1:0]  TXD_LEN,
  input  wire              TXD_LAST,
  input  wire              TXD_CONNLESS,
  input  wire [1:0]        TXD_LINK_STATE,
  output reg               TXD_READY,
  output reg               TXD_DONE,
  output reg               TXD_SENT,
  output reg               TXD_REFUSED,
  output reg               TXQ_STOP,
  input  wire              TXQ_VALID,
  input  wire [7:0]        TXQ_DATA,
  output reg               TXQ_RD,
  output reg               TXQ_FLUSH,
  input  wire              TXC,
  input  wire              CTS_N,
  output reg               RTS_N,
  output reg               TXD,
  output reg               TXD_OE_N,
  output reg               EV_URUN_THR,
  output reg               EV_CTS_LOST,
  output reg               EV_CTS_TMO,
  input  wire              RX_START,
  input  wire [POOL_W-1:0] RX_POOL,
  input  wire [15:0]       RX_LINK,
  output reg               RX_START_READY,
  input  wire              RX_BYTE_VALID,
  input  wire [7:0]        RX_BYTE,
  input  wire              RX_LAST,
  input  wire              RX_GOOD,
  input  wire [2:0]        RX_FTYPE,
  output reg               RX_BYTE_READY,
  output reg               EV_RED_LINE,
  output reg               EV_POOL_EMPTY,
  output reg               MEM_REQ,
  output reg               MEM_WE,
  output reg  [31:0]       MEM_ADDR,
  output reg  [31:0]       MEM_WDATA,
  output reg  [1:0]        MEM_SIZE,
  input  wire              MEM_ACK,
  input  wire [31:0]       MEM_RDATA
);

  localparam [3:0] T_IDLE = 4'b0001;
  localparam [3:0] T_WCTS = 4'b0010;
  localparam [3:0] T_SEND = 4'b0100;
  localparam [3:0] T_STOP = 4'b1000;

  localparam [11:0] R_IDLE      = 12'h001;
  localparam [11:0] R_ASG       = 12'h002;
  localparam [11:0] R_PTR       = 12'h004;
  localparam [11:0] R_CTL       = 12'h008;
  localparam [11:0] R_NXT       = 12'h010;
  localparam [11:0] R_BUF       = 12'h020;
  localparam [11:0] R_DATA      = 12'h040;
  localparam [11:0] R_PAD       = 12'h080;
  localparam [11:0] R_LEN       = 12'h100;
  localparam [11:0] R_CTLW      = 12'h200;
  localparam [11:0] R_PTRW      = 12'h400;
  localparam [11:0] R_DROP_CODE = 12'h800;  // Empty pool: bytes taken and thrown away

  reg [31:0]        ctrl_r;
  reg [15:0]        urun_thr_r;
  reg [31:0]        cts_tmo_r;
  reg [31:0]        pool_tbl_r;
  reg [31:0]        asg_ptr_r;
  reg [POOL_W-1:0]  asg_num_r;
  reg               asg_req_r;
  reg               asg_ack_r;
  reg               txc_s1_r, txc_s2_r, txc_s3_r;
  reg               cts_s1_r, cts_s2_r, cts_s3_r;
  reg [3:0]         tx_st_r;
  reg [LEN_W-1:0]   tx_len_r;
  reg [LEN_W-1:0]   tx_cnt_r;
  reg               tx_last_r;
  reg [2:0]         bit_cnt_r;
  reg               bit_live_r;
  reg [7:0]         shreg_r;
  reg [31:0]        cto_cnt_r;
  reg [15:0]        urun_cnt_r;
  reg [11:0]        rx_st_r;
  reg [POOL_W-1:0]  pool_r;
  reg [15:0]        link_r;
  reg [31:0]        ptr_r;
  reg [31:0]        nxt_r;
  reg [31:0]        buf_r;
  reg [31:0]        ctl_r;
  reg [15:0]        cnt_r;
  reg [7:0]         hold_r;
  reg               last_r;
  reg               good_r;
  reg [2:0]         ftype_r;
  reg [31:0]        pool_ptr [0:INT_POOLS-1];
  integer           i;

  wire txc_fall = txc_s3_r & ~txc_s2_r;   // Bits change on the falling link clock edge
  wire cts_ok   = ~cts_s2_r;
  wire narrow   = ctrl_r[`LFBM_CTRL_NARROW];
  wire pool_int = (pool_r < INT_POOLS);
  wire [31:0] pool_slot = pool_tbl_r + {{(30-POOL_W){1'b0}}, pool_r, 2'b00};
  wire [31:0] asg_slot  = pool_tbl_r + {{(30-POOL_W){1'b0}}, asg_num_r, 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  ////////////////////////////////////////////////////////////////////////////

  // Writes; the assign command hands over to the receive side by a toggle
  always @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_r     <= `LFBM_CTRL_RST;
      urun_thr_r <= `LFBM_URUN_THR_RST;
      cts_tmo_r  <= `LFBM_CTS_TMO_RST;
      pool_tbl_r <= `LFBM_POOL_TBL_RST;
      asg_ptr_r  <= 32'h0000_0000;
      asg_num_r  <= {POOL_W{1'b0}};
      asg_req_r  <= 1'b0;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `LFBM_REG_CTRL:     ctrl_r <= REG_WDATA;
        `LFBM_REG_URUN_THR: urun_thr_r <= REG_WDATA[15:0];
        `LFBM_REG_CTS_TMO:  cts_tmo_r <= REG_WDATA;
        `LFBM_REG_POOL_TBL: pool_tbl_r <= REG_WDATA;
        `LFBM_REG_ASG_PTR:  asg_ptr_r <= REG_WDATA;
        `LFBM_REG_ASG_NUM: begin
          // A second command while one is pending is ignored
          if (asg_req_r == asg_ack_r) begin
            asg_num_r <= REG_WDATA[POOL_W-1:0];
            asg_req_r <= ~asg_req_r;
          end
        end
        default: ;
      endcase
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads return zero
  always @(posedge CLK) begin
    if (SYS_RST) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `LFBM_REG_CTRL:     REG_RDATA <= ctrl_r;
        `LFBM_REG_URUN_THR: REG_RDATA <= {16'h0000, urun_thr_r};
        `LFBM_REG_CTS_TMO:  REG_RDATA <= cts_tmo_r;
        `LFBM_REG_POOL_TBL: REG_RDATA <= pool_tbl_r;
        `LFBM_REG_ASG_PTR:  REG_RDATA <= asg_ptr_r;
        `LFBM_REG_ASG_NUM:  REG_RDATA <= {{(32-POOL_W){1'b0}}, asg_num_r};
        `LFBM_REG_STATUS:   REG_RDATA <= {13'h0000, rx_st_r, tx_st_r, RTS_N, cts_ok,
                                          asg_req_r ^ asg_ack_r};
        `LFBM_REG_URUN_CNT: REG_RDATA <= {16'h0000, urun_cnt_r};
        default:            REG_RDATA <= 32'h0000_0000;
      endcase
    end else begin
      REG_RDATA <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit side
  ////////////////////////////////////////////////////////////////////////////

  // Link pins cross into CLK; the second stage is looked at, and edges are found from the second and third stages
  always @(posedge CLK) begin
    if (SYS_RST) begin
      {txc_s1_r, txc_s2_r, txc_s3_r} <= 3'b000;
      {cts_s1_r, cts_s2_r, cts_s3_r} <= 3'b111;
    end else begin
      txc_s1_r <= TXC;
      txc_s2_r <= txc_s1_r;
      txc_s3_r <= txc_s2_r;
      cts_s1_r <= CTS_N;
      cts_s2_r <= cts_s1_r;
      cts_s3_r <= cts_s2_r;
    end
  end

  // Descriptor handling, handshake wait and bit serialiser
  always @(posedge CLK) begin
    if (SYS_RST) begin
      tx_st_r     <= T_IDLE;
      tx_len_r    <= {LEN_W{1'b0}};
      tx_cnt_r    <= {LEN_W{1'b0}};
      tx_last_r   <= 1'b0;
      bit_cnt_r   <= 3'h0;
      bit_live_r  <= 1'b0;
      shreg_r     <= 8'h00;
      cto_cnt_r   <= 32'h0000_0000;
      urun_cnt_r  <= 16'h0000;
      TXD_READY   <= 1'b0;
      TXD_DONE    <= 1'b0;
      TXD_SENT    <= 1'b0;
      TXD_REFUSED <= 1'b0;
      TXQ_STOP    <= 1'b0;
      TXQ_RD      <= 1'b0;
      TXQ_FLUSH   <= 1'b0;
      RTS_N       <= 1'b1;
      TXD         <= 1'b1;
      TXD_OE_N    <= 1'b1;
      EV_URUN_THR <= 1'b0;
      EV_CTS_LOST <= 1'b0;
      EV_CTS_TMO  <= 1'b0;
    end else begin
      TXD_READY   <= 1'b0;
      TXD_DONE    <= 1'b0;
      TXQ_RD      <= 1'b0;
      TXQ_FLUSH   <= 1'b0;
      EV_URUN_THR <= 1'b0;
      EV_CTS_LOST <= 1'b0;
      EV_CTS_TMO  <= 1'b0;
      case (tx_st_r)
        T_IDLE: begin
          if (TXD_REQ && TXD_READY) begin
            TXQ_STOP <= 1'b0;
            if (TXD_CONNLESS && (TXD_LINK_STATE == `LFBM_LS_NOID ||
                                 TXD_LINK_STATE == `LFBM_LS_AWID)) begin
              TXD_DONE    <= 1'b1;
              TXD_SENT    <= 1'b0;
              TXD_REFUSED <= 1'b1;
              tx_last_r   <= TXD_LAST;
              tx_st_r     <= T_STOP;
            end else begin
              tx_len_r  <= TXD_LEN;
              tx_last_r <= TXD_LAST;
              cto_cnt_r <= 32'h0000_0000;
              RTS_N     <= 1'b0;
              tx_st_r   <= T_WCTS;
            end
          end else begin
            TXD_READY <= ~TXQ_STOP;
          end
        end
        T_WCTS: begin
          tx_cnt_r   <= {LEN_W{1'b0}};
          bit_cnt_r  <= 3'h0;
          bit_live_r <= 1'b0;
          if (cts_ok) begin
            tx_st_r <= T_SEND;
          end else if (cts_tmo_r != 32'h0000_0000) begin
            // Restarting the count gives one event per expired period
            if (cto_cnt_r + 32'h0000_0001 >= cts_tmo_r) begin
              EV_CTS_TMO <= 1'b1;
              cto_cnt_r  <= 32'h0000_0000;
            end else begin
              cto_cnt_r <= cto_cnt_r + 32'h0000_0001;
            end
          end
        end
        T_SEND: begin
          if (cts_s2_r && !cts_s3_r) begin
            EV_CTS_LOST <= 1'b1;
          end
          if (txc_fall) begin
            TXD_OE_N <= cts_s2_r;
            if (bit_live_r && bit_cnt_r != 3'h0) begin
              TXD       <= shreg_r[0];
              shreg_r   <= {1'b1, shreg_r[7:1]};
              bit_cnt_r <= bit_cnt_r - 3'h1;
              if (bit_cnt_r == 3'h1) begin
                bit_live_r <= 1'b0;
              end
            end else if (tx_cnt_r == tx_len_r) begin
              TXD_DONE    <= 1'b1;
              TXD_SENT    <= 1'b1;
              TXD_REFUSED <= 1'b0;
              TXD_OE_N    <= 1'b1;
              TXD         <= 1'b1;
              RTS_N       <= 1'b1;
              tx_st_r     <= T_STOP;
            end else if (TXQ_VALID) begin
              TXQ_RD     <= 1'b1;
              TXD        <= TXQ_DATA[0];
              shreg_r    <= {1'b1, TXQ_DATA[7:1]};
              bit_cnt_r  <= 3'h7;
              bit_live_r <= 1'b1;
              tx_cnt_r   <= tx_cnt_r + {{(LEN_W-1){1'b0}}, 1'b1};
            end else begin
              // Underrun: abort and resend from the first byte, no retry limit
              TXQ_FLUSH <= 1'b1;
              TXD_OE_N  <= 1'b1;
              TXD       <= 1'b1;
              cto_cnt_r <= 32'h0000_0000;
              tx_st_r   <= T_WCTS;
              if (urun_cnt_r + 16'h0001 >= urun_thr_r) begin
                EV_URUN_THR <= 1'b1;
                urun_cnt_r  <= 16'h0000;
              end else begin
                urun_cnt_r <= urun_cnt_r + 16'h0001;
              end
            end
          end
        end
        T_STOP: begin
          // A last descriptor parks the queue until reset, since no request is taken while it is stopped
          TXQ_STOP <= tx_last_r;
          tx_st_r  <= T_IDLE;
        end
        default: tx_st_r <= T_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive side
  ////////////////////////////////////////////////////////////////////////////

  // Starts one memory access; the request stands until acknowledged
  task mem_go;
    input        we;
    input [31:0] addr;
    input [31:0] data;
    input [1:0]  size;
    begin
      MEM_REQ   <= 1'b1;
      MEM_WE    <= we;
      MEM_ADDR  <= addr;
      MEM_WDATA <= data;
      MEM_SIZE  <= size;
    end
  endtask

  // Close the frame; a bad frame leaves its descriptor in the pool
  task rx_finish;
    begin
      if (good_r) begin
        mem_go(1'b1, ptr_r + `LFBM_FD_LEN, {16'h0000, cnt_r}, `LFBM_SZ_WORD);
        rx_st_r <= R_LEN;
      end else begin
        rx_st_r <= R_IDLE;
      end
    end
  endtask

  // Pool lookup, buffer fill and descriptor update
  always @(posedge CLK) begin
    if (SYS_RST) begin
      rx_st_r        <= R_IDLE;
      asg_ack_r      <= 1'b0;
      pool_r         <= {POOL_W{1'b0}};
      link_r         <= 16'h0000;
      ptr_r          <= 32'h0000_0000;
      nxt_r          <= 32'h0000_0000;
      buf_r          <= 32'h0000_0000;
      ctl_r          <= 32'h0000_0000;
      cnt_r          <= 16'h0000;
      hold_r         <= 8'h00;
      last_r         <= 1'b0;
      good_r         <= 1'b0;
      ftype_r        <= 3'h0;
      RX_START_READY <= 1'b0;
      RX_BYTE_READY  <= 1'b0;
      EV_RED_LINE    <= 1'b0;
      EV_POOL_EMPTY  <= 1'b0;
      MEM_REQ        <= 1'b0;
      MEM_WE         <= 1'b0;
      MEM_ADDR       <= 32'h0000_0000;
      MEM_WDATA      <= 32'h0000_0000;
      MEM_SIZE       <= `LFBM_SZ_WORD;
      for (i = 0; i < INT_POOLS; i = i + 1) begin
        pool_ptr[i] <= 32'h0000_0000;
      end
    end else begin
      RX_START_READY <= 1'b0;
      EV_RED_LINE    <= 1'b0;
      EV_POOL_EMPTY  <= 1'b0;
      if (MEM_ACK) begin
        MEM_REQ <= 1'b0;
      end
      case (rx_st_r)
        R_IDLE: begin
          if (RX_START && RX_START_READY) begin
            pool_r <= RX_POOL;
            link_r <= RX_LINK;
            if (RX_POOL < INT_POOLS) begin
              ptr_r <= pool_ptr[RX_POOL[3:0]];
              mem_go(1'b0, pool_ptr[RX_POOL[3:0]] + `LFBM_FD_CTL, 32'h0000_0000,
                     `LFBM_SZ_WORD);
              rx_st_r <= R_CTL;
            end else begin
              mem_go(1'b0, pool_tbl_r + {{(30-POOL_W){1'b0}}, RX_POOL, 2'b00},
                     32'h0000_0000, `LFBM_SZ_WORD);
              rx_st_r <= R_PTR;
            end
          end else if (asg_req_r != asg_ack_r) begin
            if (asg_num_r < INT_POOLS) begin
              pool_ptr[asg_num_r[3:0]] <= asg_ptr_r;
              asg_ack_r <= asg_req_r;
            end else begin
              mem_go(1'b1, asg_slot, asg_ptr_r, `LFBM_SZ_WORD);
              rx_st_r <= R_ASG;
            end
          end else begin
            RX_START_READY <= 1'b1;
          end
        end
        R_ASG: if (MEM_ACK) begin
          asg_ack_r <= asg_req_r;
          rx_st_r   <= R_IDLE;
        end
        R_PTR: if (MEM_ACK) begin
          ptr_r <= MEM_RDATA;
          mem_go(1'b0, MEM_RDATA + `LFBM_FD_CTL, 32'h0000_0000, `LFBM_SZ_WORD);
          rx_st_r <= R_CTL;
        end
        R_CTL: if (MEM_ACK) begin
          ctl_r <= MEM_RDATA;
          if (MEM_RDATA[`LFBM_CTL_LIP]) begin
            // Dummy reached: pool empty, frame is swallowed
            EV_POOL_EMPTY <= 1'b1;
            RX_BYTE_READY <= 1'b1;
            rx_st_r       <= R_DROP_CODE;
          end else begin
            mem_go(1'b0, ptr_r + `LFBM_FD_NEXT, 32'h0000_0000, `LFBM_SZ_WORD);
            rx_st_r <= R_NXT;
          end
        end
        R_NXT: if (MEM_ACK) begin
          nxt_r <= MEM_RDATA;
          mem_go(1'b0, ptr_r + `LFBM_FD_BUF, 32'h0000_0000, `LFBM_SZ_WORD);
          rx_st_r <= R_BUF;
        end
        R_BUF: if (MEM_ACK) begin
          buf_r         <= MEM_RDATA;
          cnt_r         <= 16'h0000;
          RX_BYTE_READY <= 1'b1;
          rx_st_r       <= R_DATA;
        end
        R_DATA: begin
          if (MEM_ACK) begin
            if (!last_r) begin
              RX_BYTE_READY <= 1'b1;
            end else if (narrow && cnt_r[0]) begin
              // Second byte write fills the unused odd byte
              mem_go(1'b1, buf_r + {16'h0000, cnt_r}, 32'h0000_0000, `LFBM_SZ_BYTE);
              rx_st_r <= R_PAD;
            end else begin
              rx_finish;
            end
          end else if (RX_BYTE_VALID && RX_BYTE_READY) begin
            last_r  <= RX_LAST;
            good_r  <= RX_GOOD;
            ftype_r <= RX_FTYPE;
            cnt_r   <= cnt_r + 16'h0001;
            hold_r  <= RX_BYTE;
            if (narrow) begin
              RX_BYTE_READY <= 1'b0;
              mem_go(1'b1, buf_r + {16'h0000, cnt_r}, {24'h00_0000, RX_BYTE},
                     `LFBM_SZ_BYTE);
            end else if (cnt_r[0]) begin
              RX_BYTE_READY <= 1'b0;
              mem_go(1'b1, buf_r + {16'h0000, cnt_r} - 32'h0000_0001,
                     {16'h0000, hold_r, RX_BYTE}, `LFBM_SZ_HALF);
            end else if (RX_LAST) begin
              // Odd count on the wide bus: one halfword write, pad not counted
              RX_BYTE_READY <= 1'b0;
              mem_go(1'b1, buf_r + {16'h0000, cnt_r}, {16'h0000, RX_BYTE, 8'h00},
                     `LFBM_SZ_HALF);
            end
          end
        end
        R_PAD: if (MEM_ACK) begin
          rx_finish;
        end
        R_LEN: if (MEM_ACK) begin
          // Nonzero frame type marks the descriptor as queued, not pool space
          mem_go(1'b1, ptr_r + `LFBM_FD_CTL,
                 {link_r, ctl_r[15:5], ftype_r, ctl_r[`LFBM_CTL_RED], 1'b0},
                 `LFBM_SZ_WORD);
          rx_st_r <= R_CTLW;
        end
        R_CTLW: if (MEM_ACK) begin
          if (pool_int) begin
            pool_ptr[pool_r[3:0]] <= nxt_r;
            EV_RED_LINE <= ctl_r[`LFBM_CTL_RED];
            rx_st_r     <= R_IDLE;
          end else begin
            mem_go(1'b1, pool_slot, nxt_r, `LFBM_SZ_WORD);
            rx_st_r <= R_PTRW;
          end
        end
        R_PTRW: if (MEM_ACK) begin
          EV_RED_LINE <= ctl_r[`LFBM_CTL_RED];
          rx_st_r     <= R_IDLE;
        end
        R_DROP_CODE: begin
          if (RX_BYTE_VALID && RX_BYTE_READY && RX_LAST) begin
            RX_BYTE_READY <= 1'b0;
            rx_st_r       <= R_IDLE;
          end
        end
        default: rx_st_r <= R_IDLE;
      endcase
    end
  end

endmodule

// ### verification/lfbm_mem_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Shared memory; answers each request one cycle late
module lfbm_mem_model (
  input  wire        clk,
  input  wire        req,
  input  wire        we,
  input  wire [31:0] addr,
  input  wire [31:0] wdata,
  output reg         ack,
  output reg  [31:0] rdata
);
  reg [31:0] m [0:63];
  initial begin
    ack = 1'b0;
    rdata = 32'h0000_0000;
  end
  // Read data turn over outside the ack cycle so stale values never pass
  always @(posedge clk) begin
    ack <= req && !ack;
    rdata <= ~rdata;
    if (req && !ack) begin
      rdata <= m[addr[7:2]];
      if (we)
        m[addr[7:2]] <= wdata;
    end
  end
endmodule

// ### verification/lfbm_top_chk.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Port watch on the buffer manager
module lfbm_top_chk (
  input wire       CLK,
  input wire       SYS_RST,
  input wire       TXD_REQ,
  input wire       TXD_CONNLESS,
  input wire [1:0] TXD_LINK_STATE,
  input wire       TXD_READY,
  input wire       TXD_DONE,
  input wire       TXD_SENT,
  input wire       TXD_REFUSED,
  input wire       TXQ_STOP,
  input wire       TXQ_FLUSH,
  input wire       TXD_OE_N,
  input wire       RTS_N,
  input wire       EV_CTS_LOST,
  input wire       EV_CTS_TMO,
  input wire       EV_POOL_EMPTY,
  input wire       MEM_REQ,
  input wire       MEM_WE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Descriptor that the link state forbids, and its answer
  sequence s_bad_req;
    TXD_REQ && TXD_READY && TXD_CONNLESS && (TXD_LINK_STATE < 2'h2);
  endsequence
  sequence s_refuse;
    TXD_DONE && TXD_REFUSED && !TXD_SENT;
  endsequence
  a_refuse_done: assert property (s_bad_req |=> s_refuse) else $error("no refusal");
  a_refuse_quiet: assert property (s_bad_req |=> RTS_N [*3]) else $error("rts on refusal");
  a_done_flags: assert property (TXD_DONE |-> TXD_SENT != TXD_REFUSED) else $error("flags");
  a_stop_hold: assert property (TXQ_STOP |-> !TXD_READY) else $error("ready when stopped");
  a_flush_float: assert property (TXQ_FLUSH |-> ##[0:1] TXD_OE_N) else $error("flush drives");
  a_lost_goes_on: assert property (EV_CTS_LOST |-> !RTS_N) else $error("frame dropped");
  a_tmo_waiting: assert property (EV_CTS_TMO |-> !RTS_N && TXD_OE_N) else $error("tmo");
  a_empty_nowrite: assert property (EV_POOL_EMPTY |-> !(MEM_REQ && MEM_WE)) else $error("wr");
endmodule
bind lfbm_top lfbm_top_chk chk (.*);

// ### verification/lfbm_top_test.sv
`timescale 1ns/1ps
`include "lfbm_consts.vh"
module lfbm_top_test;
  reg CLK = 0, SYS_RST = 1, REG_WR = 0, REG_RD = 0, TXD_REQ = 0, TXD_LAST = 0;
  reg TXD_CONNLESS = 0, TXQ_VALID = 1, TXC = 0, CTS_N = 1, RX_START = 0;
  reg RX_BYTE_VALID = 0, RX_LAST = 0, RX_GOOD = 0;
  reg [7:0] REG_ADDR = 0, TXQ_DATA = 8'h5A, RX_BYTE = 0;
  reg [31:0] REG_WDATA = 0, rd_v;
  reg [15:0] TXD_LEN = 16'h0002, RX_LINK = 16'h0005;
  reg [12:0] RX_POOL = 0;
  reg [1:0] TXD_LINK_STATE = 0;
  reg [2:0] RX_FTYPE = 0;
  wire [31:0] REG_RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA;
  wire [1:0] MEM_SIZE;
  wire TXD_READY, TXD_DONE, TXD_SENT, TXD_REFUSED, TXQ_STOP, TXQ_RD, TXQ_FLUSH, RTS_N;
  wire TXD, TXD_OE_N, EV_URUN_THR, EV_CTS_LOST, EV_CTS_TMO, RX_START_READY, RX_BYTE_READY;
  wire EV_RED_LINE, EV_POOL_EMPTY, MEM_REQ, MEM_WE, MEM_ACK;
  integer failures = 0, check_count = 0, tmo_n = 0, red_n = 0, empty_n = 0, i;
  integer urun_n = 0, flush_n = 0, lost_n = 0;
  lfbm_top uut (.*);
  lfbm_mem_model mem (.clk(CLK), .req(MEM_REQ), .we(MEM_WE), .addr(MEM_ADDR),
    .wdata(MEM_WDATA), .ack(MEM_ACK), .rdata(MEM_RDATA));
  ////////////////////////////////////////////////////////////
  // System clock and an unrelated link clock
  initial forever #10 CLK = ~CLK;
  initial begin
    #7;
    forever #80 TXC = ~TXC;
  end
  // Event pulses are one cycle long, so they are tallied here
  always @(posedge CLK) begin
    tmo_n <= tmo_n + EV_CTS_TMO;
    red_n <= red_n + EV_RED_LINE;
    empty_n <= empty_n + EV_POOL_EMPTY;
    urun_n <= urun_n + EV_URUN_THR;
    flush_n <= flush_n + TXQ_FLUSH;
    lost_n <= lost_n + EV_CTS_LOST;
  end
  ////////////////////////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge CLK);
      REG_WR <= 1'b0;
      @(posedge CLK);
    end
  endtask
  // Data stand only in the cycle after the strobe
  task rd(input [7:0] a);
    begin
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1 rd_v = REG_RDATA;
      @(posedge CLK);
    end
  endtask
  task t_regs;
    begin
      rd(`LFBM_REG_URUN_THR);
      chk(rd_v, 32'h0000_0004);
      rd(`LFBM_REG_CTS_TMO);
      chk(rd_v, 32'h0000_1000);
      rd(8'h40);
      chk(rd_v, 32'h0000_0000);
    end
  endtask
  // Connectionless frames on links without an identifier are refused
  task t_refuse(input [1:0] st);
    begin
      for (i = 0; i < 50 && TXD_READY !== 1'b1; i = i + 1) @(posedge CLK);
      TXD_CONNLESS <= 1'b1;
      TXD_LINK_STATE <= st;
      TXD_REQ <= 1'b1;
      @(posedge CLK);
      TXD_REQ <= 1'b0;
      #1 chk({TXD_DONE, TXD_REFUSED, TXD_SENT, RTS_N}, 32'h0000_000D);
      repeat (3) @(posedge CLK);
    end
  endtask
  // Timeout repeats every 20 cycles until clear-to-send, then the frame goes
  task t_cts_wait;
    begin
      wr(`LFBM_REG_CTS_TMO, 32'h0000_0014);
      for (i = 0; i < 50 && TXD_READY !== 1'b1; i = i + 1) @(posedge CLK);
      TXD_CONNLESS <= 1'b0;
      TXD_LINK_STATE <= 2'h2;
      TXD_LAST <= 1'b1;
      TXD_REQ <= 1'b1;
      @(posedge CLK);
      TXD_REQ <= 1'b0;
      repeat (75) @(posedge CLK);
      chk(tmo_n, 3);
      CTS_N <= 1'b0;
      for (i = 0; i < 400 && TXD_DONE !== 1'b1; i = i + 1) @(posedge CLK);
      #1 chk({TXD_SENT, TXQ_STOP, tmo_n[3:0]}, 32'h0000_0033);
    end
  endtask
  // Starved queue aborts twice, then the frame goes; a long CTS gap floats the pin
  task t_tx_err;
    begin
      wr(`LFBM_REG_URUN_THR, 32'h0000_0002);
      CTS_N <= 1'b0;
      TXQ_VALID <= 1'b0;
      TXD_CONNLESS <= 1'b0;
      TXD_LINK_STATE <= 2'h2;
      TXD_REQ <= 1'b1;
      @(posedge CLK);
      TXD_REQ <= 1'b0;
      for (i = 0; i < 100 && flush_n < 2; i = i + 1) @(posedge CLK);
      TXQ_VALID <= 1'b1;
      repeat (30) @(posedge CLK);
      CTS_N <= 1'b1;
      repeat (12) @(posedge CLK);
      CTS_N <= 1'b0;
      #1 chk(TXD_OE_N, 32'h0000_0001);
      for (i = 0; i < 300 && TXD_DONE !== 1'b1; i = i + 1) @(posedge CLK);
      CTS_N <= 1'b1;
      #1 chk({TXD_SENT, lost_n[3:0], flush_n[3:0], urun_n[3:0]}, 32'h0000_1121);
    end
  endtask
  task rx_byte(input [7:0] b, input last);
    begin
      RX_BYTE_VALID <= 1'b1;
      RX_BYTE <= b;
      RX_LAST <= last;
      RX_GOOD <= last;
      RX_FTYPE <= last ? 3'h3 : 3'h0;
      @(posedge CLK);
      for (i = 0; i < 40 && RX_BYTE_READY !== 1'b1; i = i + 1) @(posedge CLK);
      // Valid stays up between bytes so it is never set twice in one step
      if (last) begin
        RX_BYTE_VALID <= 1'b0;
      end
    end
  endtask
  task rx_frame;
    begin
      for (i = 0; i < 50 && RX_START_READY !== 1'b1; i = i + 1) @(posedge CLK);
      RX_START <= 1'b1;
      @(posedge CLK);
      RX_START <= 1'b0;
      rx_byte(8'h11, 1'b0);
      rx_byte(8'h22, 1'b0);
      rx_byte(8'h33, 1'b1);
      repeat (30) @(posedge CLK);
    end
  endtask
  // Pool 0: one red-line descriptor at 0x40, dummy at 0x80; even buffer
  task t_rx;
    begin
      mem.m[16] = 32'h0000_0080;
      mem.m[17] = 32'h0000_0002;
      mem.m[19] = 32'h0000_0100;
      mem.m[33] = 32'h0000_0001;
      mem.m[34] = 32'h0000_0000;
      wr(`LFBM_REG_ASG_PTR, 32'h0000_0040);
      wr(`LFBM_REG_ASG_NUM, 32'h0000_0000);
      wr(`LFBM_REG_ASG_PTR, 32'h0000_0080);
      wr(`LFBM_REG_ASG_NUM, 32'h0000_0014);
      repeat (10) @(posedge CLK);
      rx_frame;
      chk(mem.m[18], 32'h0000_0003);
      chk({mem.m[17][31:16], mem.m[17][4:2]}, 32'h0000_002B);
      chk(red_n, 1);
      rx_frame;
      chk(empty_n, 1);
      chk(mem.m[33], 32'h0000_0001);
      chk(mem.m[34], 32'h0000_0000);
      RX_POOL <= 13'h0014;
      rx_frame;
      chk(mem.m[20], 32'h0000_0080);
      chk(empty_n, 2);
    end
  endtask
  ////////////////////////////////////////////////////////////
  task tally_and_finish;
    begin
      $display("checks=%0d mismatches=%0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    #100000;
    failures = failures + 1;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b0;
    repeat (2) @(posedge CLK);
    t_regs;
    t_refuse(`LFBM_LS_NOID);
    t_refuse(`LFBM_LS_AWID);
    t_tx_err;
    t_rx;
    t_cts_wait;
    tally_and_finish;
  end
endmodule
